// ===== src/fspa_defs.svh
// Constants for the flash sector protection and access block
`ifndef FSPA_DEFS_SVH
`define FSPA_DEFS_SVH
`define FSPA_ADDR_W 16
`define FSPA_SECTOR_SIZE 16'h1000
`define FSPA_SEC0_BASE 16'hf000
`define FSPA_SEC1_BASE 16'he000
`define FSPA_SIZE_4K 17'h01000
`define FSPA_SIZE_8K 17'h02000
`define FSPA_ERASED_BYTE 8'hff
`define FSPA_CSR_ADDR 16'h0029
`define FSPA_CSR_RESET 8'h00
`define FSPA_GUARD_KEY1 8'h56
`define FSPA_GUARD_KEY2 8'hae
`define FSPA_CSR_BIT_PROG 0
`define FSPA_CSR_BIT_ERASE 1
`define FSPA_CSR_BIT_MASS 2
`define FSPA_CSR_BIT_BUSY 7
`define FSPA_LINK_CMD_W 4'h1
`define FSPA_LINK_CMD_R 4'h2
`define FSPA_LINK_CMD_SE 4'h3
`define FSPA_LINK_CMD_ME 4'h4
`define FSPA_LINK_CMD_OPT 4'h5
`define FSPA_LINK_FRAME_BITS 6'd36
`endif

// ===== src/fspa_pkg.sv
// Types shared by the flash sector protection and access block
package fspa_pkg;
  typedef enum logic [1:0] {
    FSPA_MODE_TOOL,
    FSPA_MODE_CIRCUIT,
    FSPA_MODE_APP
  } fspa_mode_t;

  typedef enum logic [2:0] {
    FSPA_OP_NONE,
    FSPA_OP_PROG,
    FSPA_OP_SECT_ERASE,
    FSPA_OP_MASS_ERASE,
    FSPA_OP_OPTION
  } fspa_op_t;

  // One request as it reaches the access checker
  typedef struct packed {
    fspa_op_t op;
    logic [15:0] addr;
    logic [7:0] data;
  } fspa_req_t;
endpackage

// ===== src/fspa_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module fspa_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta_q;
  logic meta_d;
  logic q_d;

  // Meta stage feeds only the second flop
  always_comb begin
    meta_d = d;
    q_d = meta_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end
endmodule

// ===== src/fspa_link_rx.sv
// Serial link receiver on the programming link clock
`timescale 1ns/1ps
`include "fspa_defs.svh"
module fspa_link_rx
  import fspa_pkg::*;
(
  input wire logic prog_link_clock,
  input wire logic rst,
  input wire logic data_in,
  output logic [35:0] frame_q,
  output logic frame_tgl_q
);
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [35:0] shift_q;
  logic [35:0] shift_d;
  logic [35:0] frame_d;
  logic frame_tgl_d;

  // Shift MSB first; a full frame flips the toggle for the main domain
  always_comb begin
    shift_d = {shift_q[34:0], data_in};
    cnt_d = cnt_q + 6'd1;
    frame_d = frame_q;
    frame_tgl_d = frame_tgl_q;
    if (cnt_q == `FSPA_LINK_FRAME_BITS - 6'd1) begin
      cnt_d = 6'd0;
      frame_d = shift_d;
      frame_tgl_d = ~frame_tgl_q;
    end
  end

  always_ff @(posedge prog_link_clock or posedge rst) begin
    if (rst) begin
      cnt_q <= 6'd0;
      shift_q <= 36'h0;
      frame_q <= 36'h0;
      frame_tgl_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      frame_q <= frame_d;
      frame_tgl_q <= frame_tgl_d;
    end
  end
endmodule

// ===== src/fspa_top.sv
// Flash sector protection, mode gating and programming link
// Behaviour
// - Erase whole array or one sector
// - Program one byte per write
// - Tool mode: all sectors and options writable
// - In-circuit mode: all sectors and options writable
// - In-application mode: all but sector 0
// - Sectors 0 and 1 are 4 KB
// - Sector 0 spans top 4 KB
// - Sector count follows array size
// - Sector erase leaves other sectors intact
// - Protection blocks link readout and array writes; CPU reads still return array data
// - Removing protection starts a mass erase in the same cycle the bit clears
// - One option bit controls protection
// - Key sequence guards CPU program and erase; link frames need no keys
// - Link uses four to six connections
// - Separate link clock; data pin receive-only, output enable held low
// - Sector 0 locked in in-application mode
// - Control register at 0029h resets zero
`timescale 1ns/1ps
`include "fspa_defs.svh"
module fspa_top
  import fspa_pkg::*;
#(
  parameter logic [16:0] FLASH_SIZE = 17'h10000
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic prog_link_clock,
  input wire logic prog_link_data_in,
  output logic prog_link_data_out,
  output logic prog_link_data_oe,
  input wire logic prog_select_voltage,
  input wire logic tool_socket,
  input wire logic cpu_we,
  input wire logic cpu_re,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic [7:0] link_rdata,
  output logic readout_protect,
  output logic busy
);
  localparam int MEM_BYTES = 65536;
  // Lowest mapped address of the array; sectors grow downward from the top
  localparam logic [16:0] MEM_LIMIT = 17'h10000;
  localparam logic [15:0] ARRAY_BASE = 16'(MEM_LIMIT - FLASH_SIZE);

  logic [7:0] mem [0:MEM_BYTES-1];

  // Link domain receiver, crossing by toggle plus stable frame word
  logic [35:0] link_frame;
  logic link_tgl;
  logic link_tgl_s;
  logic vpp_s;
  logic sock_s;
  fspa_link_rx u_rx (
    .prog_link_clock(prog_link_clock),
    .rst(rst),
    .data_in(prog_link_data_in),
    .frame_q(link_frame),
    .frame_tgl_q(link_tgl)
  );
  fspa_sync u_s_tgl (.clk(clk), .rst(rst), .d(link_tgl), .q(link_tgl_s));
  fspa_sync u_s_vpp (.clk(clk), .rst(rst), .d(prog_select_voltage), .q(vpp_s));
  fspa_sync u_s_sock (.clk(clk), .rst(rst), .d(tool_socket), .q(sock_s));

  logic tgl_seen_q, tgl_seen_d;
  logic [7:0] csr_q, csr_d;
  logic [1:0] guard_q, guard_d;
  logic rop_q, rop_d;
  logic [7:0] cpu_rdata_d, link_rdata_d;
  logic busy_d;
  logic [16:0] wipe_q, wipe_d;
  logic wiping_q, wiping_d;
  logic [16:0] wipe_end_q, wipe_end_d;
  fspa_mode_t mode;
  fspa_req_t req;
  logic allowed;
  logic mem_we;
  logic [15:0] mem_wa;
  logic [7:0] mem_wd;

  // Mode: socket strap wins, else voltage select means in-circuit session
  always_comb begin
    if (sock_s) mode = FSPA_MODE_TOOL;
    else if (vpp_s) mode = FSPA_MODE_CIRCUIT;
    else mode = FSPA_MODE_APP;
  end

  // Sector lookup by address; tolerates arrays of one, two or three sectors
  function automatic logic [1:0] sector_of(input logic [15:0] a);
    if (a >= `FSPA_SEC0_BASE) sector_of = 2'd0;
    else if (a >= `FSPA_SEC1_BASE) sector_of = 2'd1;
    else sector_of = 2'd2;
  endfunction

  function automatic logic mapped(input logic [15:0] a);
    mapped = (a >= ARRAY_BASE);
  endfunction

  // Request source: a received link frame in a session, else the CPU guard
  always_comb begin
    req = '{op: FSPA_OP_NONE, addr: 16'h0, data: 8'h0};
    tgl_seen_d = link_tgl_s;
    guard_d = guard_q;
    csr_d = csr_q;
    if (link_tgl_s != tgl_seen_q && mode != FSPA_MODE_APP) begin
      req.addr = link_frame[31:16];
      req.data = link_frame[15:8];
      case (link_frame[35:32])
        `FSPA_LINK_CMD_W: req.op = FSPA_OP_PROG;
        `FSPA_LINK_CMD_SE: req.op = FSPA_OP_SECT_ERASE;
        `FSPA_LINK_CMD_ME: req.op = FSPA_OP_MASS_ERASE;
        `FSPA_LINK_CMD_OPT: req.op = FSPA_OP_OPTION;
        default: req.op = FSPA_OP_NONE;
      endcase
    end else if (cpu_we && cpu_addr == `FSPA_CSR_ADDR) begin
      // Two-key unlock before any control write takes effect
      if (guard_q == 2'd0 && cpu_wdata == `FSPA_GUARD_KEY1) guard_d = 2'd1;
      else if (guard_q == 2'd1 && cpu_wdata == `FSPA_GUARD_KEY2) guard_d = 2'd2;
      else if (guard_q == 2'd2) begin
        csr_d = cpu_wdata;
        guard_d = 2'd0;
      end else guard_d = 2'd0;
    end else if (cpu_we && csr_q[`FSPA_CSR_BIT_PROG]) begin
      req = '{op: FSPA_OP_PROG, addr: cpu_addr, data: cpu_wdata};
      csr_d = `FSPA_CSR_RESET;
    end else if (cpu_we && csr_q[`FSPA_CSR_BIT_ERASE]) begin
      req.op = csr_q[`FSPA_CSR_BIT_MASS] ? FSPA_OP_MASS_ERASE : FSPA_OP_SECT_ERASE;
      req.addr = cpu_addr;
      csr_d = `FSPA_CSR_RESET;
    end
    if (wiping_q) begin
      req.op = FSPA_OP_NONE; // Busy: a request during an erase is dropped
    end
    csr_d[`FSPA_CSR_BIT_BUSY] = wiping_d;
  end

  // Permission check by mode, sector and protection
  always_comb begin
    allowed = 1'b0;
    case (req.op)
      FSPA_OP_PROG, FSPA_OP_SECT_ERASE: begin
        allowed = mapped(req.addr) && !rop_q;
        if (mode == FSPA_MODE_APP && sector_of(req.addr) == 2'd0) allowed = 1'b0;
      end
      FSPA_OP_MASS_ERASE: allowed = (mode != FSPA_MODE_APP) && !rop_q;
      FSPA_OP_OPTION: allowed = (mode != FSPA_MODE_APP);
      default: allowed = 1'b0;
    endcase
  end

  // Erase sequencer: one byte per cycle over a sector or the whole array
  always_comb begin
    wipe_d = wipe_q;
    wiping_d = wiping_q;
    wipe_end_d = wipe_end_q;
    rop_d = rop_q;
    mem_we = 1'b0;
    mem_wa = 16'h0;
    mem_wd = `FSPA_ERASED_BYTE;
    if (wiping_q) begin
      mem_we = 1'b1;
      mem_wa = wipe_q[15:0];
      wipe_d = wipe_q + 17'd1;
      if (wipe_d == wipe_end_q) wiping_d = 1'b0;
    end else if (allowed) begin
      case (req.op)
        FSPA_OP_PROG: begin
          mem_we = 1'b1;
          mem_wa = req.addr;
          mem_wd = req.data;
        end
        FSPA_OP_SECT_ERASE: begin
          // Bounds are the sector's own, so neighbours stay untouched
          wiping_d = 1'b1;
          wipe_end_d = {1'b0, req.addr[15:12], 12'h0} + {1'b0, `FSPA_SECTOR_SIZE};
          wipe_d = {1'b0, req.addr[15:12], 12'h0};
          if (sector_of(req.addr) == 2'd2) wipe_d = {1'b0, ARRAY_BASE};
          if (sector_of(req.addr) == 2'd2) wipe_end_d = {1'b0, `FSPA_SEC1_BASE};
        end
        FSPA_OP_MASS_ERASE: begin
          wiping_d = 1'b1;
          wipe_d = {1'b0, ARRAY_BASE};
          wipe_end_d = MEM_LIMIT;
        end
        FSPA_OP_OPTION: begin
          rop_d = req.data[0];
          if (rop_q && !req.data[0]) begin
            wiping_d = 1'b1;
            wipe_d = {1'b0, ARRAY_BASE};
            wipe_end_d = MEM_LIMIT;
          end
        end
        default: mem_we = 1'b0;
      endcase
    end
  end

  // Readback: protection hides the array from the link, CPU still runs code
  always_comb begin
    cpu_rdata_d = (cpu_addr == `FSPA_CSR_ADDR) ? csr_q : mem[cpu_addr];
    link_rdata_d = rop_q ? 8'h00 : mem[link_frame[31:16]];
    busy_d = wiping_d;
  end

  always_ff @(posedge clk) begin
    if (ce && mem_we) mem[mem_wa] <= mem_wd;
  end

  // Option bit resets clear; a real part would load it from nonvolatile storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tgl_seen_q <= 1'b0;
      csr_q <= `FSPA_CSR_RESET;
      guard_q <= 2'd0;
      rop_q <= 1'b0;
      wipe_q <= 17'h0;
      wiping_q <= 1'b0;
      wipe_end_q <= 17'h0;
      cpu_rdata <= 8'h00;
      link_rdata <= 8'h00;
      busy <= 1'b0;
      readout_protect <= 1'b0;
      prog_link_data_out <= 1'b0;
      prog_link_data_oe <= 1'b0;
    end else if (ce) begin
      tgl_seen_q <= tgl_seen_d;
      csr_q <= csr_d;
      guard_q <= guard_d;
      rop_q <= rop_d;
      wipe_q <= wipe_d;
      wiping_q <= wiping_d;
      wipe_end_q <= wipe_end_d;
      cpu_rdata <= cpu_re ? cpu_rdata_d : cpu_rdata;
      link_rdata <= link_rdata_d;
      busy <= busy_d;
      readout_protect <= rop_d;
      prog_link_data_out <= 1'b0;
      prog_link_data_oe <= 1'b0; // Data pin is receive-only here
    end
  end

  AST_APP_SEC0: assert property (@(posedge clk) disable iff (rst)
    (mode == FSPA_MODE_APP && req.op == FSPA_OP_PROG && req.addr >= `FSPA_SEC0_BASE)
    |-> !allowed) else $error("Sector 0 write allowed in application mode");
  AST_ROP_WRITE: assert property (@(posedge clk) disable iff (rst)
    (rop_q && req.op == FSPA_OP_PROG) |-> !allowed) else $error("Write under protection");
  AST_ROP_REMOVE: assert property (@(posedge clk) disable iff (rst)
    (ce && allowed && req.op == FSPA_OP_OPTION && rop_q && !req.data[0]) |=> wiping_q)
    else $error("No mass erase on unprotect");
  AST_CSR_RESET: assert property (@(posedge clk) $fell(rst) |-> csr_q == `FSPA_CSR_RESET)
    else $error("Control register not zero after reset");
  AST_FORBID: assert property (@(posedge clk) disable iff (rst)
    (!allowed && !wiping_q) |-> !mem_we) else $error("Forbidden request wrote array");
  AST_PROG_BYTE: assert property (@(posedge clk) disable iff (rst)
    (allowed && req.op == FSPA_OP_PROG && !wiping_q) |-> (mem_we && mem_wa == req.addr))
    else $error("Program not single byte");
  AST_SECT_BOUND: assert property (@(posedge clk) disable iff (rst)
    wiping_q |-> (wipe_q < wipe_end_q)) else $error("Erase outside bounds");
  AST_GUARD: assert property (@(posedge clk) disable iff (rst)
    (ce && cpu_we && cpu_addr == `FSPA_CSR_ADDR && guard_q != 2'd2 && !wiping_q
     && link_tgl_s == tgl_seen_q) |=> csr_q[6:0] == $past(csr_q[6:0]))
    else $error("Control written without unlock");
endmodule

// ===== tb/fspa_tool_model.sv
// Programming tool model: drives the link clock and link data
`timescale 1ns/1ps
module fspa_tool_model (
  output logic prog_link_clock,
  output logic link_data_drv
);
  // Clock idles low, one pulse that rises while reset is held; released data shows its inverse
  initial begin
    prog_link_clock = 1'b0;
    link_data_drv = 1'b1;
    #20 prog_link_clock = 1'b1;
    #32 prog_link_clock = 1'b0;
  end
  // One frame MSB first, 64 ns bit time, data moved while the clock is low
  task automatic send_frame(input logic [35:0] fr);
    #13;
    for (int i = 35; i >= 0; i--) begin
      link_data_drv = fr[i];
      #32 prog_link_clock = 1'b1;
      #32 prog_link_clock = 1'b0;
    end
    link_data_drv = ~fr[0];
  endtask
endmodule

// ===== tb/fspa_top_tb.sv
// Self-checking bench for the flash sector protection and access block
`timescale 1ns/1ps
module fspa_top_tb;
  import fspa_pkg::*;
  localparam logic [16:0] FSIZE = 17'h02000;
  localparam int BASE = 32'h10000 - int'(FSIZE);
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic sel_v = 1'b0;
  logic sock = 1'b1;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic [15:0] lfsr = 16'h1c8e; // Seed 7310
  logic link_clk, tool_d, link_wire, dout, doe, prot, busy;
  logic [7:0] rdata, lrdata;
  logic [7:0] mem [int];
  logic [15:0] al [4] = '{16'hffff, 16'hf000, 16'hefff, 16'he000};
  bit m_prot = 1'b0;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;

  // Main clock, 10 ns period, generated in the bench itself
  always #5 clk = ~clk;
  // Data wire resolved from both drivers
  assign link_wire = doe ? dout : tool_d;
  // Link: clock, data, select, reset and ground
  fspa_top #(.FLASH_SIZE(FSIZE)) u_fspa_top (
    .clk(clk), .rst(rst), .ce(ce), .prog_link_clock(link_clk),
    .prog_link_data_in(link_wire), .prog_link_data_out(dout), .prog_link_data_oe(doe),
    .prog_select_voltage(sel_v), .tool_socket(sock), .cpu_we(we), .cpu_re(re),
    .cpu_addr(addr), .cpu_wdata(wdata), .cpu_rdata(rdata), .link_rdata(lrdata),
    .readout_protect(prot), .busy(busy)
  );
  fspa_tool_model u_fspa_tool_model (.prog_link_clock(link_clk), .link_data_drv(tool_d));

  // Cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      end_of_test();
    end
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction
  // Reference: may this byte change in the present mode and protection
  function automatic bit may_alter(logic [15:0] a);
    return int'(a) >= BASE && !m_prot && !(!sock && !sel_v && a >= 16'hf000);
  endfunction
  function automatic void m_erase(logic [15:0] a, bit whole);
    foreach (mem[k]) if (whole || k[15:12] == a[15:12]) mem[k] = 8'hff;
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask

  // Bus strobes are held across back-to-back writes; idle() drops them
  task automatic cpu_wr(input logic [15:0] a, input logic [7:0] d);
    #1;
    we = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
  endtask
  task automatic idle();
    #1;
    we = 1'b0;
    re = 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_idle();
    repeat (3) @(posedge clk);
    #1;
    for (int i = 0; i < 20000 && busy === 1'b1; i++) @(posedge clk) #1;
  endtask
  task automatic cpu_rd_chk(input logic [15:0] a);
    #1;
    re = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    re = 1'b0;
    chk8(rdata, mem.exists(a) ? mem[a] : 8'h00, "cpu read");
    @(posedge clk);
  endtask
  // Two keys, control value, then the operation itself
  task automatic cpu_op(input logic [7:0] k2, input logic [7:0] ctl, input logic [15:0] a);
    bit ok;
    logic [7:0] d;
    ok = k2 == 8'hae && may_alter(a);
    d = rnd();
    cpu_wr(16'h0029, 8'h56);
    cpu_wr(16'h0029, k2);
    cpu_wr(16'h0029, ctl);
    cpu_wr(a, d);
    idle();
    if (ctl == 8'h02) begin
      #1 chk1(busy, ok, "erase busy");
      if (ok) m_erase(a, 1'b0);
    end else if (ok) begin
      mem[a] = d;
    end
    wait_idle();
  endtask
  task automatic link_op(input logic [3:0] cmd, input logic [15:0] a, input logic [7:0] d);
    bit ok;
    bit mass;
    ok = (sock || sel_v) && may_alter(a);
    mass = cmd == 4'h5 && m_prot && !d[0];
    u_fspa_tool_model.send_frame({cmd, a, d, 8'h00});
    repeat (8) @(posedge clk);
    #1;
    if (cmd == 4'h5) m_prot = d[0];
    if (mass) m_erase(a, 1'b1);
    if (cmd == 4'h1 && ok) mem[a] = d;
    if (cmd == 4'h3 && ok) m_erase(a, 1'b0);
    if (cmd == 4'h3 || mass) begin
      chk1(busy, ok || mass, "erase busy");
      wait_idle();
    end
  endtask
  task automatic link_rd_chk(input logic [15:0] a);
    link_op(4'h2, a, 8'h00);
    chk8(lrdata, m_prot ? 8'h00 : mem[a], "link read");
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence: tool socket, in-application, in-circuit, protection
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    #1 chk1(prot, 1'b0, "protect at reset");
    chk1(busy, 1'b0, "busy at reset");
    chk1(doe, 1'b0, "data enable");
    chk1(dout, 1'b0, "data out");
    cpu_rd_chk(16'h0029);
    foreach (al[i]) cpu_op(8'hae, 8'h01, al[i]);
    foreach (al[i]) cpu_rd_chk(al[i]);
    cpu_op(8'h00, 8'h01, 16'hf000);
    cpu_rd_chk(16'hf000);
    #1 sock = 1'b0;
    repeat (4) @(posedge clk);
    foreach (al[i]) cpu_op(8'hae, 8'h01, al[i]);
    cpu_op(8'hae, 8'h02, 16'hf123);
    link_op(4'h1, 16'he000, 8'h33);
    cpu_op(8'hae, 8'h02, 16'he456);
    foreach (al[i]) cpu_rd_chk(al[i]);
    #1 sel_v = 1'b1;
    repeat (4) @(posedge clk);
    foreach (al[i]) link_op(4'h1, al[i], rnd());
    link_op(4'h3, 16'hf800, 8'h00);
    foreach (al[i]) link_rd_chk(al[i]);
    link_op(4'h5, 16'h0000, 8'h01);
    chk1(prot, 1'b1, "protect on");
    link_op(4'h1, al[3], 8'h11);
    cpu_op(8'hae, 8'h01, al[2]);
    link_rd_chk(al[3]);
    link_op(4'h5, 16'h0000, 8'h00);
    chk1(prot, 1'b0, "protect off");
    foreach (al[i]) cpu_rd_chk(al[i]);
    // Clock enable low: a full unlock and write must leave the array alone
    #1 ce = 1'b0;
    cpu_wr(16'h0029, 8'h56);
    cpu_wr(16'h0029, 8'hae);
    cpu_wr(16'h0029, 8'h01);
    cpu_wr(al[1], 8'h5a);
    idle();
    #1 ce = 1'b1;
    cpu_rd_chk(al[1]);
    cpu_rd_chk(16'h0029);
    end_of_test();
  end
endmodule
